// *** pkg/tcu_pkg.sv ***
// register map, field positions, reset values and mode codes of the
// 8-bit timer/counter with two compare channels.
// assumes a 32-bit apb slave on pclk; only the low byte of each word is used.
package tcu_pkg;

  // register byte offsets
  localparam logic [7:0] TCU_OFS_CTRL_A = 8'h00;
  localparam logic [7:0] TCU_OFS_CTRL_B = 8'h04;
  localparam logic [7:0] TCU_OFS_COUNT  = 8'h08;
  localparam logic [7:0] TCU_OFS_CMP_A  = 8'h0C;
  localparam logic [7:0] TCU_OFS_CMP_B  = 8'h10;
  localparam logic [7:0] TCU_OFS_MASK   = 8'h14;
  localparam logic [7:0] TCU_OFS_FLAGS  = 8'h18;

  // timer_control_a: action a [7:6], action b [5:4], mode bits 1:0 [1:0]
  localparam int TCU_CA_ACT_A = 6;
  localparam int TCU_CA_ACT_B = 4;
  localparam int TCU_CA_WGM0  = 0;
  // timer_control_b: force a [7], force b [6], mode bit 2 [3], select [2:0]
  localparam int TCU_CB_FOC_A = 7;
  localparam int TCU_CB_FOC_B = 6;
  localparam int TCU_CB_WGM2  = 3;
  localparam int TCU_CB_CS    = 0;

  // flag and mask bit positions
  localparam int TCU_F_OVF = 0;
  localparam int TCU_F_CMA = 1;
  localparam int TCU_F_CMB = 2;

  // count extremes
  localparam logic [7:0] TCU_BOTTOM = 8'h00;
  localparam logic [7:0] TCU_MAX    = 8'hFF;

  // reset values
  localparam logic [7:0] TCU_RST_BYTE  = 8'h00;
  localparam logic [2:0] TCU_RST_FLAGS = 3'h0;
  localparam logic [1:0] TCU_RST_ACT   = 2'h0;

  // clock select codes
  localparam logic [2:0] TCU_CS_OFF  = 3'h0;
  localparam logic [2:0] TCU_CS_D1   = 3'h1;
  localparam logic [2:0] TCU_CS_D8   = 3'h2;
  localparam logic [2:0] TCU_CS_D64  = 3'h3;
  localparam logic [2:0] TCU_CS_D256 = 3'h4;
  localparam logic [2:0] TCU_CS_D1K  = 3'h5;
  localparam logic [2:0] TCU_CS_FALL = 3'h6;
  localparam logic [2:0] TCU_CS_RISE = 3'h7;

  // prescaler masks: tick when the masked low bits are all ones
  localparam logic [9:0] TCU_PM_D8   = 10'h007;
  localparam logic [9:0] TCU_PM_D64  = 10'h03F;
  localparam logic [9:0] TCU_PM_D256 = 10'h0FF;
  localparam logic [9:0] TCU_PM_D1K  = 10'h3FF;

  // waveform modes; 4 and 6 behave as normal
  localparam logic [2:0] TCU_WGM_NORMAL = 3'h0;
  localparam logic [2:0] TCU_WGM_PC_FF  = 3'h1;
  localparam logic [2:0] TCU_WGM_CTC    = 3'h2;
  localparam logic [2:0] TCU_WGM_FP_FF  = 3'h3;
  localparam logic [2:0] TCU_WGM_PC_OCA = 3'h5;
  localparam logic [2:0] TCU_WGM_FP_OCA = 3'h7;

  // compare output actions
  localparam logic [1:0] TCU_ACT_NONE = 2'h0;
  localparam logic [1:0] TCU_ACT_TGL  = 2'h1;
  localparam logic [1:0] TCU_ACT_CLR  = 2'h2;
  localparam logic [1:0] TCU_ACT_SET  = 2'h3;

  // how the counter sequences
  typedef enum logic [3:0] {
    TCU_SEQ_NORMAL = 4'h1,
    TCU_SEQ_CTC    = 4'h2,
    TCU_SEQ_FAST   = 4'h4,
    TCU_SEQ_PHASE  = 4'h8
  } tcu_seq_type;

endpackage : tcu_pkg

// *** design/tcu_timer8.sv ***
// 8-bit timer/counter with two compare channels and port override.
// assumes an apb master on pclk; ack inputs and port bits come from
// logic on pclk, the external count pin is asynchronous.
`default_nettype none

module tcu_timer8
  import tcu_pkg::*;
(
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // external count pin
  input  wire logic        count_pin,
  // interrupt service acknowledges
  input  wire logic        ack_ovf,
  input  wire logic        ack_cmp_a,
  input  wire logic        ack_cmp_b,
  // interrupt requests
  output logic             irq_ovf,
  output logic             irq_cmp_a,
  output logic             irq_cmp_b,
  // general port bits of the two compare pins
  input  wire logic        port_out_a,
  input  wire logic        port_out_b,
  input  wire logic        compare_pin_direction_bit_a,
  input  wire logic        compare_pin_direction_bit_b,
  // pins
  output logic             wave_output_a,
  output logic             wave_output_a_oe,
  output logic             wave_output_b,
  output logic             wave_output_b_oe
);

  typedef struct packed {
    logic [7:0]  cnt;
    logic        down;
    logic        block;
    logic [7:0]  cmp_a;
    logic [7:0]  cmp_b;
    logic [7:0]  buf_a;
    logic [7:0]  buf_b;
    logic [1:0]  act_a;
    logic [1:0]  act_b;
    logic [2:0]  wgm;
    logic [2:0]  cs;
    logic [2:0]  mask;
    logic [2:0]  flags;
    logic        oc_a;
    logic        oc_b;
    logic [9:0]  presc;
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_old;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        irq_o;
    logic        irq_a;
    logic        irq_b;
    logic        pa;
    logic        pa_oe;
    logic        pb;
    logic        pb_oe;
  } tcu_state_type;

  tcu_state_type st_ff;
  tcu_state_type nxt_st;

  // non-pwm action on a match or forced compare
  function automatic logic tcu_act(input logic [1:0] act, input logic oc);
    case (act)
      TCU_ACT_TGL: tcu_act = ~oc;
      TCU_ACT_CLR: tcu_act = 1'b0;
      TCU_ACT_SET: tcu_act = 1'b1;
      default:     tcu_act = oc;
    endcase
  endfunction : tcu_act

  // pwm output rule: clear/set on match, opposite level at the turn
  function automatic logic tcu_pwm(input logic [1:0] act,
                                   input logic       oc,
                                   input logic       match,
                                   input logic       turn,
                                   input logic       lvl,
                                   input logic       tgl_ok);
    tcu_pwm = oc;
    if (act == TCU_ACT_TGL && tgl_ok && match) begin
      tcu_pwm = ~oc;
    end else if (act == TCU_ACT_CLR || act == TCU_ACT_SET) begin
      if (match) begin
        tcu_pwm = (act == TCU_ACT_SET) ? lvl : ~lvl;
      end else if (turn) begin
        tcu_pwm = (act == TCU_ACT_SET) ? ~lvl : lvl;
      end
    end
  endfunction : tcu_pwm

  // nonzero action replaces the port value
  function automatic logic tcu_pin(input logic [1:0] act,
                                   input logic       oc,
                                   input logic       port);
    tcu_pin = (act != TCU_ACT_NONE) ? oc : port;
  endfunction : tcu_pin

  tcu_seq_type seq;
  logic [7:0]  top;
  logic        pwm;
  logic        tick;
  logic        edge_r;
  logic        edge_f;
  logic        match_a;
  logic        match_b;
  logic        turn;
  logic        at_top;
  logic        wr;
  logic        rd_setup;
  logic        tgl_ok;
  logic [7:0]  wd;
  logic        ovf_ev;

  always_comb begin
    nxt_st = st_ff;
    wd     = pwdata[7:0];

    // mode field gathered from both control registers
    case (st_ff.wgm)
      TCU_WGM_PC_FF, TCU_WGM_PC_OCA: seq = TCU_SEQ_PHASE;
      TCU_WGM_FP_FF, TCU_WGM_FP_OCA: seq = TCU_SEQ_FAST;
      TCU_WGM_CTC:                   seq = TCU_SEQ_CTC;
      default:                       seq = TCU_SEQ_NORMAL;
    endcase
    pwm = (seq == TCU_SEQ_FAST) || (seq == TCU_SEQ_PHASE);
    // top is max or compare a
    top = (st_ff.wgm == TCU_WGM_PC_OCA || st_ff.wgm == TCU_WGM_FP_OCA) ?
          st_ff.cmp_a : TCU_MAX;
    tgl_ok = st_ff.wgm[2];

    // free-running prescaler; only pin_s2 and later stages are read
    nxt_st.presc   = st_ff.presc + 10'h001;
    nxt_st.pin_s1  = count_pin;
    nxt_st.pin_s2  = st_ff.pin_s1;
    nxt_st.pin_old = st_ff.pin_s2;
    edge_r = st_ff.pin_s2 & ~st_ff.pin_old;
    edge_f = ~st_ff.pin_s2 & st_ff.pin_old;

    case (st_ff.cs)
      TCU_CS_D1:   tick = 1'b1;
      TCU_CS_D8:   tick = &(st_ff.presc | ~TCU_PM_D8);
      TCU_CS_D64:  tick = &(st_ff.presc | ~TCU_PM_D64);
      TCU_CS_D256: tick = &(st_ff.presc | ~TCU_PM_D256);
      TCU_CS_D1K:  tick = &(st_ff.presc | ~TCU_PM_D1K);
      TCU_CS_FALL: tick = edge_f;
      TCU_CS_RISE: tick = edge_r;
      default:     tick = 1'b0;
    endcase

    match_a = (st_ff.cnt == st_ff.cmp_a) && !st_ff.block;
    match_b = (st_ff.cnt == st_ff.cmp_b) && !st_ff.block;
    at_top  = (st_ff.cnt == top);
    turn    = 1'b0;

    // ovf cleared here and merged back below, so a fresh event is known
    nxt_st.flags[TCU_F_OVF] = 1'b0;
    if (tick) begin
      nxt_st.block = 1'b0;
      // clear, increment or decrement per mode
      case (seq)
        TCU_SEQ_CTC: begin
          nxt_st.cnt = (st_ff.cnt == st_ff.cmp_a) ? TCU_BOTTOM :
                       st_ff.cnt + 8'h01;
          if (st_ff.cnt == TCU_MAX) begin
            nxt_st.flags[TCU_F_OVF] = 1'b1;
          end
        end
        TCU_SEQ_FAST: begin
          nxt_st.cnt = at_top ? TCU_BOTTOM : st_ff.cnt + 8'h01;
          turn       = at_top;
          if (at_top) begin
            nxt_st.flags[TCU_F_OVF] = 1'b1;
            nxt_st.cmp_a = st_ff.buf_a;
            nxt_st.cmp_b = st_ff.buf_b;
          end
        end
        TCU_SEQ_PHASE: begin
          if (!st_ff.down) begin
            if (st_ff.cnt >= top) begin
              nxt_st.down  = 1'b1;
              nxt_st.cnt   = (st_ff.cnt == TCU_BOTTOM) ? TCU_BOTTOM :
                             st_ff.cnt - 8'h01;
              nxt_st.cmp_a = st_ff.buf_a;
              nxt_st.cmp_b = st_ff.buf_b;
            end else begin
              nxt_st.cnt = st_ff.cnt + 8'h01;
            end
          end else if (st_ff.cnt == TCU_BOTTOM) begin
            nxt_st.down = 1'b0;
            nxt_st.cnt  = st_ff.cnt + 8'h01;
            nxt_st.flags[TCU_F_OVF] = 1'b1;
          end else begin
            nxt_st.cnt = st_ff.cnt - 8'h01;
          end
        end
        default: begin
          nxt_st.cnt = st_ff.cnt + 8'h01;
          if (st_ff.cnt == TCU_MAX) begin
            nxt_st.flags[TCU_F_OVF] = 1'b1;
          end
        end
      endcase

      // match sets flag on this tick
      if (match_a) begin
        nxt_st.flags[TCU_F_CMA] = 1'b1;
      end
      if (match_b) begin
        nxt_st.flags[TCU_F_CMB] = 1'b1;
      end

      // live action bits decide each match
      if (seq == TCU_SEQ_FAST) begin
        nxt_st.oc_a = tcu_pwm(st_ff.act_a, st_ff.oc_a, match_a, turn,
                              1'b1, tgl_ok);
        nxt_st.oc_b = tcu_pwm(st_ff.act_b, st_ff.oc_b, match_b, turn,
                              1'b1, 1'b0);
      end else if (seq == TCU_SEQ_PHASE) begin
        nxt_st.oc_a = tcu_pwm(st_ff.act_a, st_ff.oc_a, match_a, 1'b0,
                              ~st_ff.down, tgl_ok);
        nxt_st.oc_b = tcu_pwm(st_ff.act_b, st_ff.oc_b, match_b, 1'b0,
                              ~st_ff.down, 1'b0);
      end else begin
        if (match_a) begin
          nxt_st.oc_a = tcu_act(st_ff.act_a, st_ff.oc_a);
        end
        if (match_b) begin
          nxt_st.oc_b = tcu_act(st_ff.act_b, st_ff.oc_b);
        end
      end
    end

    ovf_ev = nxt_st.flags[TCU_F_OVF];
    nxt_st.flags[TCU_F_OVF] = ovf_ev | st_ff.flags[TCU_F_OVF];

    // serviced interrupt clears flag; a new event wins
    if (ack_ovf && !ovf_ev) begin
      nxt_st.flags[TCU_F_OVF] = 1'b0;
    end
    if (ack_cmp_a && !(tick && match_a)) begin
      nxt_st.flags[TCU_F_CMA] = 1'b0;
    end
    if (ack_cmp_b && !(tick && match_b)) begin
      nxt_st.flags[TCU_F_CMB] = 1'b0;
    end

    // apb: answer one cycle after setup, no wait states
    rd_setup     = psel && !penable;
    wr           = psel && penable && pwrite && st_ff.ready;
    nxt_st.ready = rd_setup;
    nxt_st.err   = 1'b0;
    if (rd_setup) begin
      nxt_st.rdata = 32'h0000_0000;
      case (paddr)
        TCU_OFS_CTRL_A: begin
          nxt_st.rdata[7:0] = {st_ff.act_a, st_ff.act_b, 2'h0,
                               st_ff.wgm[1:0]};
        end
        TCU_OFS_CTRL_B: begin
          nxt_st.rdata[7:0] = {4'h0, st_ff.wgm[2], st_ff.cs};
        end
        TCU_OFS_COUNT: nxt_st.rdata[7:0] = st_ff.cnt;
        // reads see buffer in pwm modes
        TCU_OFS_CMP_A: nxt_st.rdata[7:0] = pwm ? st_ff.buf_a : st_ff.cmp_a;
        TCU_OFS_CMP_B: nxt_st.rdata[7:0] = pwm ? st_ff.buf_b : st_ff.cmp_b;
        TCU_OFS_MASK:  nxt_st.rdata[2:0] = st_ff.mask;
        TCU_OFS_FLAGS: nxt_st.rdata[2:0] = st_ff.flags;
        default:       nxt_st.err = 1'b1;
      endcase
    end

    if (wr) begin
      case (paddr)
        TCU_OFS_CTRL_A: begin
          // mode change leaves output state alone
          nxt_st.act_a    = wd[TCU_CA_ACT_A +: 2];
          nxt_st.act_b    = wd[TCU_CA_ACT_B +: 2];
          nxt_st.wgm[1:0] = wd[TCU_CA_WGM0 +: 2];
        end
        TCU_OFS_CTRL_B: begin
          nxt_st.wgm[2] = wd[TCU_CB_WGM2];
          nxt_st.cs     = wd[TCU_CB_CS +: 3];
          if (!pwm && wd[TCU_CB_FOC_A]) begin
            nxt_st.oc_a = tcu_act(st_ff.act_a, nxt_st.oc_a);
          end
          if (!pwm && wd[TCU_CB_FOC_B]) begin
            nxt_st.oc_b = tcu_act(st_ff.act_b, nxt_st.oc_b);
          end
        end
        TCU_OFS_COUNT: begin
          nxt_st.cnt   = wd;
          nxt_st.block = 1'b1;
        end
        // buffer in pwm, active register otherwise
        TCU_OFS_CMP_A: begin
          nxt_st.buf_a = wd;
          if (!pwm) begin
            nxt_st.cmp_a = wd;
          end
        end
        TCU_OFS_CMP_B: begin
          nxt_st.buf_b = wd;
          if (!pwm) begin
            nxt_st.cmp_b = wd;
          end
        end
        TCU_OFS_MASK: nxt_st.mask = wd[2:0];
        TCU_OFS_FLAGS: begin
          // write one clears; hardware set wins
          if (wd[TCU_F_OVF] && !ovf_ev) begin
            nxt_st.flags[TCU_F_OVF] = 1'b0;
          end
          if (wd[TCU_F_CMA] && !(tick && match_a)) begin
            nxt_st.flags[TCU_F_CMA] = 1'b0;
          end
          if (wd[TCU_F_CMB] && !(tick && match_b)) begin
            nxt_st.flags[TCU_F_CMB] = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    nxt_st.irq_o = nxt_st.flags[TCU_F_OVF] & nxt_st.mask[TCU_F_OVF];
    nxt_st.irq_a = nxt_st.flags[TCU_F_CMA] & nxt_st.mask[TCU_F_CMA];
    nxt_st.irq_b = nxt_st.flags[TCU_F_CMB] & nxt_st.mask[TCU_F_CMB];

    nxt_st.pa = tcu_pin(nxt_st.act_a, nxt_st.oc_a, port_out_a);
    nxt_st.pb = tcu_pin(nxt_st.act_b, nxt_st.oc_b, port_out_b);
    nxt_st.pa_oe = compare_pin_direction_bit_a;
    nxt_st.pb_oe = compare_pin_direction_bit_b;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff       <= '0;
      st_ff.flags <= TCU_RST_FLAGS;
      st_ff.act_a <= TCU_RST_ACT;
      st_ff.act_b <= TCU_RST_ACT;
      st_ff.cnt   <= TCU_RST_BYTE;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign prdata           = st_ff.rdata;
  assign pready           = st_ff.ready;
  assign pslverr          = st_ff.err;
  assign irq_ovf          = st_ff.irq_o;
  assign irq_cmp_a        = st_ff.irq_a;
  assign irq_cmp_b        = st_ff.irq_b;
  assign wave_output_a    = st_ff.pa;
  assign wave_output_a_oe = st_ff.pa_oe;
  assign wave_output_b    = st_ff.pb;
  assign wave_output_b_oe = st_ff.pb_oe;

endmodule : tcu_timer8

`default_nettype wire

// *** test/tcu_timer8_assertions.sv ***
// checker: apb answer, irq causes and pin a selection of tcu_timer8
// assumes ce is held high; sees the top module's ports only
`default_nettype none
module tcu_timer8_assertions
  import tcu_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // interrupt a
  input wire logic        ack_cmp_a,
  input wire logic        irq_cmp_a,
  // pin a
  input wire logic        port_out_a,
  input wire logic        compare_pin_direction_bit_a,
  input wire logic        wave_output_a,
  input wire logic        wave_output_a_oe
);
  logic [1:0] act_ff, old_ff, up_ff;
  logic       mask_ff, wr, clr, bad;
  assign wr  = psel && penable && pwrite && pready;
  assign clr = wr && (paddr == TCU_OFS_FLAGS || paddr == TCU_OFS_MASK);
  assign bad = paddr[1:0] != 2'h0 || paddr > TCU_OFS_FLAGS;
  // up_ff hides the edges right after release, when pins still read 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ff  <= TCU_RST_ACT;
      old_ff  <= TCU_RST_ACT;
      up_ff   <= 2'h0;
      mask_ff <= 1'b0;
    end else begin
      old_ff <= act_ff;
      if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
      if (wr && paddr == TCU_OFS_CTRL_A) act_ff <= pwdata[TCU_CA_ACT_A +: 2];
      if (wr && paddr == TCU_OFS_MASK) mask_ff <= pwdata[TCU_F_CMA];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (s_done |=> !pready)
    else $error("ready held too long");
  a_error_on_map: assert property (
    (s_setup ##1 s_done) |-> pslverr == bad)
    else $error("error flag does not match the map");
  a_upper_bytes_zero: assert property (
    pready |-> prdata[31:8] == 24'h0)
    else $error("read data above the byte");
  a_enable_from_dir: assert property (
    up_ff == 2'h3 |->
    wave_output_a_oe == $past(compare_pin_direction_bit_a))
    else $error("pin enable not from direction");
  a_port_when_idle: assert property (
    up_ff == 2'h3 && act_ff == 2'h0 && old_ff == 2'h0 |->
    wave_output_a == $past(port_out_a))
    else $error("pin not from port value");
  a_irq_fall_cause: assert property (
    $fell(irq_cmp_a) |-> $past(ack_cmp_a) || $past(clr))
    else $error("request dropped without cause");
  a_irq_needs_mask: assert property (
    $rose(irq_cmp_a) |-> mask_ff || $past(mask_ff))
    else $error("request raised while masked");
endmodule : tcu_timer8_assertions

bind tcu_timer8 tcu_timer8_assertions u_tcu_timer8_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ack_cmp_a(ack_cmp_a),
  .irq_cmp_a(irq_cmp_a), .port_out_a(port_out_a),
  .compare_pin_direction_bit_a(compare_pin_direction_bit_a),
  .wave_output_a(wave_output_a), .wave_output_a_oe(wave_output_a_oe)
);
`default_nettype wire

// *** test/tcu_isr_model.sv ***
// interrupt service model: acknowledges pending requests one at a time
// assumes request levels and acknowledge pulses on pclk
`default_nettype none
module tcu_isr_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // service on, and extra latency
  input  wire logic       en,
  input  wire logic       slow,
  // requests and acknowledges: ovf, a, b
  input  wire logic [2:0] irq,
  output logic      [2:0] ack
);
  logic [3:0] wait_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack     <= 3'h0;
      wait_ff <= 4'h0;
    end else begin
      ack <= 3'h0;
      if (en && irq != 3'h0 && ack == 3'h0) begin
        wait_ff <= wait_ff + 4'h1;
        if (wait_ff >= (slow ? 4'h9 : 4'h0)) begin
          ack     <= irq & (~irq + 3'h1);
          wait_ff <= 4'h0;
        end
      end
    end
  end
endmodule : tcu_isr_model
`default_nettype wire

// *** test/tcu_timer8_bench.sv ***
// bench of tcu_timer8: apb tasks, isr model, pin and count checks
// assumes the package register map; ce tied high, one clock
`default_nettype none
module tcu_timer8_bench
  import tcu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pin, port_a, port_b;
  logic        dir_a, dir_b, en, slow, rdy, err, ev, oc, wa, wb, oea;
  logic        oeb, io, ia, ib;
  logic [2:0]  ack;
  logic [1:0]  act;
  logic [7:0]  paddr, rv, c, v;
  logic [31:0] pwdata, prdata;
  logic [2:0]  modes [3] = '{TCU_WGM_CTC, TCU_WGM_PC_OCA, TCU_WGM_FP_OCA};
  int          n_mismatch = 0, checked = 0, i, n;
  always #2.5 pclk = ~pclk;
  tcu_timer8 u_tcu_timer8 (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(rdy), .pslverr(err),
    .count_pin(pin), .ack_ovf(ack[0]), .ack_cmp_a(ack[1]),
    .ack_cmp_b(ack[2]), .irq_ovf(io), .irq_cmp_a(ia), .irq_cmp_b(ib),
    .port_out_a(port_a), .port_out_b(port_b),
    .compare_pin_direction_bit_a(dir_a),
    .compare_pin_direction_bit_b(dir_b), .wave_output_a(wa),
    .wave_output_a_oe(oea), .wave_output_b(wb), .wave_output_b_oe(oeb));
  tcu_isr_model u_tcu_isr_model (.pclk(pclk), .presetn(presetn),
    .en(en), .slow(slow), .irq({ib, ia, io}), .ack(ack));
  task automatic chk(input string s, input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, d);
    int k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until pready is seen high at a rising edge, or 50 edges have passed
    do begin
      @(posedge pclk);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    n_mismatch += int'(rdy !== 1'b1);
    rv = prdata[7:0];
    ev = err;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string s, input logic [7:0] a, e);
    bus(1'b0, a, 8'h00);
    chk(s, rv, e);
  endtask : rdc
  task automatic pulses(input int k);
    repeat (k) begin
      repeat (4) @(posedge pclk);
      pin <= 1'b1;
      repeat (4) @(posedge pclk);
      pin <= 1'b0;
    end
  endtask : pulses
  function automatic logic oc_after(input logic o, input logic [1:0] a);
    case (a)
      TCU_ACT_TGL: return ~o;
      TCU_ACT_CLR: return 1'b0;
      TCU_ACT_SET: return 1'b1;
      default:     return o;
    endcase
  endfunction : oc_after
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, pin, en, slow, port_a} <= 8'h00;
    {port_b, dir_a, dir_b, paddr, pwdata} <= {3'h3, 40'h0};
    void'($urandom(32'h9869726B));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rdc("reset", 8'(i * 4), 8'h00);
      chk("unmapped", 8'(ev), 8'(i == 7));
    end
    port_a <= 1'b1;
    wr(TCU_OFS_CTRL_A, 8'hF0);
    repeat (2) @(posedge pclk);
    chk("oc_reset", 8'(wa), 8'h00);
    chk("pin_dir", 8'(oea), 8'h01);
    chk("pin_dir_b", 8'(oeb), 8'h01);
    oc = 1'b0;
    v = 8'($urandom);
    wr(TCU_OFS_COUNT, v);
    for (i = 0; i < 8; i++) begin
      act = (i < 4) ? 2'(i) : 2'($urandom);
      port_a <= 1'($urandom);
      wr(TCU_OFS_CTRL_A, {act, act, 4'h0});
      wr(TCU_OFS_CTRL_B, 8'hC0);
      oc = oc_after(oc, act);
      wr(TCU_OFS_CTRL_A, 8'h50);
      repeat (2) @(posedge pclk);
      chk("force_a", 8'(wa), 8'(oc));
      chk("force_b", 8'(wb), 8'(oc));
    end
    rdc("no_flag", TCU_OFS_FLAGS, 8'h00);
    rdc("no_reload", TCU_OFS_COUNT, v);
    wr(TCU_OFS_CTRL_A, 8'h53);
    repeat (2) @(posedge pclk);
    chk("mode_keep", 8'(wa), 8'(oc));
    wr(TCU_OFS_CTRL_A, 8'h00);
    c = 8'($urandom_range(224, 16));
    wr(TCU_OFS_CMP_A, c);
    wr(TCU_OFS_CMP_B, c + 8'h01);
    wr(TCU_OFS_COUNT, c);
    wr(TCU_OFS_CTRL_B, {5'h0, TCU_CS_D1});
    repeat (4) @(posedge pclk);
    rdc("blocked", TCU_OFS_FLAGS, 8'h04);
    repeat (300) @(posedge pclk);
    wr(TCU_OFS_CTRL_B, 8'h00);
    rdc("all_set", TCU_OFS_FLAGS, 8'h07);
    wr(TCU_OFS_MASK, 8'h01);
    repeat (2) @(posedge pclk);
    chk("req_ovf", 8'(io), 8'h01);
    wr(TCU_OFS_FLAGS, 8'h05);
    rdc("one_clears", TCU_OFS_FLAGS, 8'h02);
    chk("ovf_cleared", 8'(io), 8'h00);
    chk("masked", 8'(ia), 8'h00);
    wr(TCU_OFS_MASK, 8'h07);
    repeat (2) @(posedge pclk);
    chk("request", 8'(ia), 8'h01);
    chk("no_req_b", 8'(ib), 8'h00);
    slow <= 1'($urandom);
    en <= 1'b1;
    repeat (40) @(posedge pclk);
    rdc("serviced", TCU_OFS_FLAGS, 8'h00);
    chk("req_gone", 8'(ia), 8'h00);
    en <= 1'b0;
    v = 8'($urandom);
    wr(TCU_OFS_CTRL_B, {5'h0, TCU_CS_D1});
    wr(TCU_OFS_COUNT, v);
    wr(TCU_OFS_CTRL_B, 8'h00);
    bus(1'b0, TCU_OFS_COUNT, 8'h00);
    v = rv - v;
    chk("write_wins", 8'(v inside {8'h02, 8'h03}), 8'h01);
    foreach (modes[j]) begin
      c = 8'($urandom_range(48, 4));
      wr(TCU_OFS_CTRL_A, 8'h00);
      wr(TCU_OFS_CMP_A, c);
      wr(TCU_OFS_COUNT, 8'h00);
      wr(TCU_OFS_CTRL_A, {6'h0, modes[j][1:0]});
      wr(TCU_OFS_CMP_A, c);
      rdc("buffer", TCU_OFS_CMP_A, c);
      wr(TCU_OFS_CTRL_B, {4'h0, modes[j][2], TCU_CS_D1});
      repeat ($urandom_range(300, 50)) @(posedge pclk);
      wr(TCU_OFS_CTRL_B, 8'h00);
      bus(1'b0, TCU_OFS_COUNT, 8'h00);
      chk("in_range", 8'(rv <= c), 8'h01);
    end
    wr(TCU_OFS_CTRL_A, 8'h00);
    for (i = 0; i < 2; i++) begin
      n = $urandom_range(9, 3);
      wr(TCU_OFS_COUNT, 8'h00);
      wr(TCU_OFS_CTRL_B, {5'h0, (i == 0) ? TCU_CS_RISE : TCU_CS_FALL});
      pulses(n);
      repeat (8) @(posedge pclk);
      wr(TCU_OFS_CTRL_B, 8'h00);
      pulses(2);
      rdc("pin_edges", TCU_OFS_COUNT, 8'(n));
    end
    print_verdict();
  end
endmodule : tcu_timer8_bench
`default_nettype wire
